//--- core/analog_out_param_diag.sv
// Behaviour
// - short_detect_enable bits 0..3 enable short detection per channel; bits 7..4 reserved.
// - range code FFh switches the channel output off.
// - code 10h: 27648 is 10 V, overrange up to 32511 accepted.
// - code 20h: 16384 is 10 V, overrange up to 20480 accepted.
// - negative values clamp to 0 V; no underrange output.
// - an error lights that channel's indicator and enters the diagnostic record.
// - no diagnostic interrupt; diagnostics only returned when the coupler reads.
// - report parameter errors; shorts only on channels with detection enabled.
// - record 01h returns full diagnostics, record 00h the first four bytes.
// - flag byte: failure, internal, external, channel, aux missing, parameter error bits.
// - module information byte reads 15h: class 0101b plus channel-info flag.
// - fourth byte: bit 3 buffer overflow, bit 4 internal communication error.
// - channel kind byte reads 73h, analog output.
// - diagnostic bits per channel 08h and channel count 04h, adjacent bytes.
// - four channel error bytes, four reserved bytes, then four timestamp bytes.
// - summary byte bits 0..3 mark channel groups in error; upper bits reserved.
// - channel byte: bit 0 parameter error, bit 3 short to ground.
// - free microsecond counter from 0, wrapping; captured on each diagnostic event.
module analog_out_param_diag #(
  parameter int NUM_CH = 4
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire aout_diag_pkg::rec_req_type rec_req,
  output aout_diag_pkg::rec_rsp_type     rec_rsp,
  input  wire logic [NUM_CH-1:0][15:0]   out_value,
  input  wire logic [NUM_CH-1:0]         short_sense,
  input  wire logic                      aux_supply_missing,
  input  wire logic                      module_fault,
  input  wire logic                      diag_buffer_overflow,
  input  wire logic                      internal_comm_error,
  output logic [NUM_CH-1:0][11:0]        dac_code,
  output logic [NUM_CH-1:0]              channel_active,
  output logic [NUM_CH-1:0]              channel_error_led,
  output logic                           group_error_led
);

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // pin inputs: three flops, a change is taken once stages two and three agree
  localparam int PINS = NUM_CH + 1;
  logic [PINS-1:0] pin_s1_ff;
  logic [PINS-1:0] pin_s2_ff;
  logic [PINS-1:0] pin_s3_ff;
  logic [PINS-1:0] pin_ok_ff;
  logic [PINS-1:0] nxt_pin_ok;
  // stages agree: take stage three, so a cleared pin clears too; disagree: hold the last accepted level
  assign nxt_pin_ok = ((pin_s2_ff ~^ pin_s3_ff) & pin_s3_ff)
                    | ((pin_s2_ff ^ pin_s3_ff) & pin_ok_ff);
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
      pin_ok_ff <= '0;
    end else begin
      pin_s1_ff <= {aux_supply_missing, short_sense};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ok_ff <= nxt_pin_ok;
    end
  end

  logic [NUM_CH-1:0] short_seen;
  logic              aux_missing_seen;
  assign short_seen       = pin_ok_ff[NUM_CH-1:0];
  assign aux_missing_seen = pin_ok_ff[NUM_CH];

  // parameter store: short enables and range codes
  logic [7:0]              short_en_ff;
  logic [NUM_CH-1:0][7:0]  range_code_ff;

  // request decode
  logic       is_param;
  logic       is_diag_full;
  logic       is_diag_short;
  logic       is_range;
  logic [1:0] range_sel;
  logic       index_ok;
  logic       wr_short_en;
  logic       wr_range;
  assign is_param      = rec_req.valid && rec_req.write && rec_req.record_number == aout_diag_pkg::REC_PARAM;
  assign is_diag_full  = rec_req.valid && !rec_req.write
                         && rec_req.record_number == aout_diag_pkg::REC_DIAG_FULL;
  assign is_diag_short = rec_req.valid && !rec_req.write
                         && rec_req.record_number == aout_diag_pkg::REC_DIAG_SHORT;
  assign is_range      = rec_req.valid && rec_req.record_number >= aout_diag_pkg::REC_RANGE_BASE
                         && rec_req.record_number <= aout_diag_pkg::REC_RANGE_LAST;
  assign range_sel     = rec_req.record_number[1:0];
  assign index_ok      = (is_param      && rec_req.byte_index < aout_diag_pkg::PARAM_LEN)
                      || (is_diag_full  && rec_req.byte_index < aout_diag_pkg::DIAG_LEN)
                      || (is_diag_short && rec_req.byte_index < aout_diag_pkg::DIAG_SHORT_LEN)
                      || (is_range      && rec_req.byte_index < aout_diag_pkg::RANGE_LEN);
  assign wr_short_en   = is_param && rec_req.byte_index == aout_diag_pkg::PAR_SHORT_EN;
  assign wr_range      = is_range && rec_req.write && index_ok;

  // reserved byte 0 and bits 7..4 of the enable byte never store anything
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      short_en_ff   <= aout_diag_pkg::SHORT_EN_RST;
      range_code_ff <= {NUM_CH{aout_diag_pkg::RANGE_RST}};
    end else begin
      if (wr_short_en) short_en_ff <= rec_req.wr_data & aout_diag_pkg::SHORT_EN_MASK;
      if (wr_range) range_code_ff[range_sel] <= rec_req.wr_data;
    end
  end

  // per channel scaling, clamping and error detection
  logic [NUM_CH-1:0][7:0]  chan_err;
  logic [NUM_CH-1:0][11:0] nxt_dac;
  logic [NUM_CH-1:0]       nxt_active;
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    logic        wide;
    logic        narrow;
    logic        off;
    logic        bad_code;
    logic [14:0] clamped;
    logic [13:0] gain;
    logic [28:0] product;
    assign wide     = range_code_ff[c] == aout_diag_pkg::RANGE_WIDE;
    assign narrow   = range_code_ff[c] == aout_diag_pkg::RANGE_NARROW;
    assign off      = range_code_ff[c] == aout_diag_pkg::RANGE_OFF;
    assign bad_code = !wide && !narrow && !off;
    // negative clamps to zero, above overrange clamps to the limit
    assign clamped  = out_value[c][15] ? 15'h0000
                    : (wide && out_value[c] > aout_diag_pkg::WIDE_OVER) ? aout_diag_pkg::WIDE_OVER[14:0]
                    : (narrow && out_value[c] > aout_diag_pkg::NARROW_OVER) ? aout_diag_pkg::NARROW_OVER[14:0]
                    : out_value[c][14:0];
    assign gain     = wide ? aout_diag_pkg::WIDE_GAIN : aout_diag_pkg::NARROW_GAIN;
    assign product  = 29'(clamped * gain);
    assign nxt_active[c] = wide || narrow;
    assign nxt_dac[c]    = nxt_active[c] ? product[aout_diag_pkg::SCALE_SHIFT +: 12] : 12'h000;
    // errors are levels: they fall as soon as the cause does
    assign chan_err[c] = {4'h0,
                          short_seen[c] && short_en_ff[c] && nxt_active[c],
                          2'b00,
                          bad_code};
  end

  // analog side outputs are registered; an inactive channel sits at code zero
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      dac_code       <= '0;
      channel_active <= '0;
    end else begin
      dac_code       <= nxt_dac;
      channel_active <= nxt_active;
    end
  end

  // summary and flag bytes
  logic [NUM_CH-1:0] chan_fault;
  logic [7:0]        summary;
  logic [7:0]        flags;
  logic [7:0]        internal;
  logic              any_param;
  logic              any_short;
  for (genvar c = 0; c < NUM_CH; c++) begin : g_fault
    assign chan_fault[c] = |chan_err[c];
  end
  always_comb begin
    any_param = 1'b0;
    any_short = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      any_param = any_param | chan_err[c][aout_diag_pkg::CH_PARAM_ERROR];
      any_short = any_short | chan_err[c][aout_diag_pkg::CH_SHORT_GROUND];
    end
  end
  assign summary = 8'(chan_fault);
  always_comb begin
    flags = 8'h00;
    flags[aout_diag_pkg::FLAG_MODULE_FAIL] = module_fault;
    flags[aout_diag_pkg::FLAG_INTERNAL]    = internal_comm_error || diag_buffer_overflow;
    flags[aout_diag_pkg::FLAG_EXTERNAL]    = any_short;
    flags[aout_diag_pkg::FLAG_CHANNEL]     = |chan_fault;
    flags[aout_diag_pkg::FLAG_AUX_MISSING] = aux_missing_seen;
    flags[aout_diag_pkg::FLAG_PARAM]       = any_param;
    internal = 8'h00;
    internal[aout_diag_pkg::INT_BUF_OVERFLOW] = diag_buffer_overflow;
    internal[aout_diag_pkg::INT_COMM_ERROR]   = internal_comm_error;
  end

  // indicators follow the error bytes directly
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      channel_error_led <= '0;
      group_error_led   <= 1'b0;
    end else begin
      channel_error_led <= chan_fault;
      group_error_led   <= |flags;
    end
  end

  // microsecond ticker; runs from reset and wraps naturally at 2^32
  logic [4:0]  us_div_ff;
  logic [31:0] us_count_ff;
  logic        us_tick;
  assign us_tick = us_div_ff == aout_diag_pkg::US_CYCLES - 5'h01;
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      us_div_ff   <= 5'h00;
      us_count_ff <= 32'h0000_0000;
    end else begin
      us_div_ff   <= us_tick ? 5'h00 : us_div_ff + 5'h01;
      us_count_ff <= us_tick ? us_count_ff + 32'h0000_0001 : us_count_ff;
    end
  end

  // a diagnostic event is any change of the reported error picture
  logic [NUM_CH*8+15:0] err_view;
  logic [NUM_CH*8+15:0] err_view_ff;
  logic [31:0]          stamp_ff;
  logic                 diag_event;
  assign err_view   = {chan_err, flags, internal};
  assign diag_event = err_view != err_view_ff;
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      err_view_ff <= '0;
      stamp_ff    <= 32'h0000_0000;
    end else begin
      err_view_ff <= err_view;
      if (diag_event) stamp_ff <= us_count_ff;
    end
  end

  // diagnostic record image, 20 bytes
  logic [19:0][7:0] diag_rec;
  always_comb begin
    diag_rec = '0;
    diag_rec[aout_diag_pkg::DG_FLAGS]    = flags;
    diag_rec[aout_diag_pkg::DG_MODINFO]  = aout_diag_pkg::MODINFO_VAL;
    diag_rec[aout_diag_pkg::DG_INTERNAL] = internal;
    diag_rec[aout_diag_pkg::DG_KIND]     = aout_diag_pkg::KIND_VAL;
    diag_rec[aout_diag_pkg::DG_BITS]     = aout_diag_pkg::BITS_VAL;
    diag_rec[aout_diag_pkg::DG_COUNT]    = aout_diag_pkg::COUNT_VAL;
    diag_rec[aout_diag_pkg::DG_SUMMARY]  = summary;
    for (int c = 0; c < NUM_CH; c++) begin
      diag_rec[aout_diag_pkg::DG_CHAN0 + 5'(c)] = chan_err[c];
    end
    for (int b = 0; b < 4; b++) begin
      diag_rec[aout_diag_pkg::DG_STAMP + 5'(b)] = stamp_ff[8*(3-b) +: 8]; // most significant first
    end
  end

  // read data selection; writes read back nothing
  logic [7:0] rd_sel;
  assign rd_sel = !index_ok || rec_req.write ? 8'h00
                : is_range ? range_code_ff[range_sel]
                : diag_rec[rec_req.byte_index];

  // one answer per request, always a cycle later; nothing is ever pushed unasked
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rec_rsp <= '0;
    end else begin
      rec_rsp.ack     <= rec_req.valid;
      rec_rsp.err     <= rec_req.valid && !index_ok;
      rec_rsp.rd_data <= rec_req.valid ? rd_sel : 8'h00;
    end
  end

endmodule : analog_out_param_diag

//--- inc/aout_diag_pkg.sv
package aout_diag_pkg;

  // record numbers seen on the coupler port
  localparam logic [7:0] REC_PARAM       = 8'h00;
  localparam logic [7:0] REC_DIAG_SHORT  = 8'h00;
  localparam logic [7:0] REC_DIAG_FULL   = 8'h01;
  localparam logic [7:0] REC_RANGE_BASE  = 8'h80;
  localparam logic [7:0] REC_RANGE_LAST  = 8'h83;

  // record lengths in bytes
  localparam logic [4:0] DIAG_LEN        = 5'h14;
  localparam logic [4:0] DIAG_SHORT_LEN  = 5'h04;
  localparam logic [4:0] PARAM_LEN       = 5'h02;
  localparam logic [4:0] RANGE_LEN       = 5'h01;

  // byte positions inside the parameter and diagnostic records
  localparam logic [4:0] PAR_RESERVED    = 5'h00;
  localparam logic [4:0] PAR_SHORT_EN    = 5'h01;
  localparam logic [4:0] DG_FLAGS        = 5'h00;
  localparam logic [4:0] DG_MODINFO      = 5'h01;
  localparam logic [4:0] DG_RSVD         = 5'h02;
  localparam logic [4:0] DG_INTERNAL     = 5'h03;
  localparam logic [4:0] DG_KIND         = 5'h04;
  localparam logic [4:0] DG_BITS        = 5'h05;
  localparam logic [4:0] DG_COUNT        = 5'h06;
  localparam logic [4:0] DG_SUMMARY      = 5'h07;
  localparam logic [4:0] DG_CHAN0        = 5'h08;
  localparam logic [4:0] DG_STAMP        = 5'h10;

  // reset and constant values
  localparam logic [7:0] SHORT_EN_RST    = 8'h00;
  localparam logic [7:0] SHORT_EN_MASK   = 8'h0f;
  localparam logic [7:0] RANGE_RST       = 8'h10;
  localparam logic [7:0] MODINFO_VAL     = 8'h15;
  localparam logic [7:0] KIND_VAL        = 8'h73;
  localparam logic [7:0] BITS_VAL        = 8'h08;
  localparam logic [7:0] COUNT_VAL       = 8'h04;

  // output range codes
  localparam logic [7:0] RANGE_WIDE      = 8'h10;
  localparam logic [7:0] RANGE_NARROW    = 8'h20;
  localparam logic [7:0] RANGE_OFF       = 8'hff;

  // digital limits per range
  localparam logic [15:0] WIDE_NOMINAL   = 16'h6c00;
  localparam logic [15:0] WIDE_OVER      = 16'h7eff;
  localparam logic [15:0] NARROW_NOMINAL = 16'h4000;
  localparam logic [15:0] NARROW_OVER    = 16'h5000;

  // converter full scale is 12.5 V so the largest overrange still fits
  localparam longint DAC_MAX_CODE   = 4095;
  localparam longint DAC_FULL_MV    = 12500;
  localparam longint NOMINAL_MV     = 10000;
  localparam int     SCALE_SHIFT    = 16;
  localparam logic [13:0] WIDE_GAIN   = 14'((DAC_MAX_CODE * NOMINAL_MV * 65536) / (DAC_FULL_MV * 27648));
  localparam logic [13:0] NARROW_GAIN = 14'((DAC_MAX_CODE * NOMINAL_MV * 65536) / (DAC_FULL_MV * 16384));

  // diagnostic flag bit positions
  localparam int FLAG_MODULE_FAIL  = 0;
  localparam int FLAG_INTERNAL     = 1;
  localparam int FLAG_EXTERNAL     = 2;
  localparam int FLAG_CHANNEL      = 3;
  localparam int FLAG_AUX_MISSING  = 4;
  localparam int FLAG_PARAM        = 7;
  localparam int INT_BUF_OVERFLOW  = 3;
  localparam int INT_COMM_ERROR    = 4;
  localparam int CH_PARAM_ERROR    = 0;
  localparam int CH_SHORT_GROUND   = 3;

  // microsecond ticker timing
  localparam longint CLK_HZ        = 20000000;
  localparam longint TICK_US       = 1;
  localparam logic [4:0] US_CYCLES = 5'((CLK_HZ * TICK_US) / 1000000);

  // one record access from the coupler
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] record_number;
    logic [4:0] byte_index;
    logic [7:0] wr_data;
  } rec_req_type;

  // registered answer to that access
  typedef struct packed {
    logic       ack;
    logic       err;
    logic [7:0] rd_data;
  } rec_rsp_type;

endpackage : aout_diag_pkg

//--- tb/aout_diag_monitor.sv
module aout_diag_monitor #(
  parameter int NUM_CH = 4
) (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire aout_diag_pkg::rec_req_type rec_req,
  input wire aout_diag_pkg::rec_rsp_type rec_rsp,
  input wire logic [NUM_CH-1:0][11:0]    dac_code,
  input wire logic [NUM_CH-1:0]          channel_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // full record read and off-channel output check
  logic rd01;
  logic dac_bad;
  assign rd01 = rec_req.valid && !rec_req.write && rec_req.record_number == 8'h01;
  always_comb begin
    dac_bad = 1'b0;
    for (int i = 0; i < NUM_CH; i++) if (!channel_active[i] && dac_code[i] != 12'h000) dac_bad = 1'b1;
  end
  ack_next_cycle_a: assert property (rec_req.valid |=> rec_rsp.ack)
    else $error("no answer one cycle after request");
  ack_unasked_a: assert property (!rec_req.valid |=> !rec_rsp.ack && !rec_rsp.err)
    else $error("answer without request");
  idle_data_zero_a: assert property (!rec_rsp.ack |-> rec_rsp.rd_data == 8'h00)
    else $error("read data outside answer");
  modinfo_value_a: assert property (rd01 && rec_req.byte_index == 5'h01 |=> rec_rsp.rd_data == 8'h15)
    else $error("module information byte wrong");
  kind_value_a: assert property (rd01 && rec_req.byte_index == 5'h04 |=> rec_rsp.rd_data == 8'h73)
    else $error("channel kind byte wrong");
  count_bytes_a: assert property (rd01 && rec_req.byte_index inside {5'h05, 5'h06} |=>
    rec_rsp.rd_data == (($past(rec_req.byte_index) == 5'h05) ? 8'h08 : 8'h04)) else $error("count bytes wrong");
  rsvd_zero_a: assert property (rd01 && rec_req.byte_index inside {5'h02, [5'h0c:5'h0f]} |=>
    rec_rsp.rd_data == 8'h00) else $error("reserved byte not zero");
  short_rec_err_a: assert property (rec_req.valid && !rec_req.write && rec_req.record_number == 8'h00 &&
    rec_req.byte_index > 5'h03 |=> rec_rsp.ack && rec_rsp.err) else $error("short record overrun accepted");
  unknown_rec_err_a: assert property (rec_req.valid && rec_req.record_number inside {[8'h02:8'h7f]} |=>
    rec_rsp.err && rec_rsp.rd_data == 8'h00) else $error("unknown record accepted");
  off_dac_zero_a: assert property (!dac_bad)
    else $error("inactive channel drives output");
  cover property (rd01 ##1 rec_rsp.ack);
  cover property (rec_req.valid && rec_req.write && rec_req.record_number == 8'h82);
  cover property ($fell(channel_active[0]));
endmodule : aout_diag_monitor

bind analog_out_param_diag aout_diag_monitor #(.NUM_CH(NUM_CH)) aout_diag_monitor_inst (.clk(clk),
  .rst_n(rst_n), .rec_req(rec_req), .rec_rsp(rec_rsp), .dac_code(dac_code), .channel_active(channel_active));

//--- tb/coupler_model.sv
module coupler_model (
  input  wire logic                       clk,
  output aout_diag_pkg::rec_req_type      rec_req,
  input  wire aout_diag_pkg::rec_rsp_type rec_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rec_req = '0;
  // one byte access: strobe one cycle, answer taken the cycle after
  // released fields show inverted values so stale data never looks good
  task automatic access(input logic wr, input logic [7:0] rec, input logic [4:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic er);
    @(negedge clk);
    rec_req <= '{1'b1, wr, rec, idx, wd};
    @(negedge clk);
    rd = rec_rsp.rd_data;
    er = rec_rsp.err | ~rec_rsp.ack;
    rec_req <= '{1'b0, ~wr, ~rec, ~idx, ~wd};
  endtask : access
endmodule : coupler_model

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       clk, rst_n, aux_supply_missing, module_fault, group_error_led;
  logic                       diag_buffer_overflow, internal_comm_error, er;
  aout_diag_pkg::rec_req_type rec_req;
  aout_diag_pkg::rec_rsp_type rec_rsp;
  logic [3:0][15:0]           out_value;
  logic [3:0][11:0]           dac_code;
  logic [3:0]                 short_sense, channel_active, channel_error_led;
  logic [7:0]                 rd, code;
  logic [31:0]                seed, t1, t2;
  int                         fails, checks, cyc;
  analog_out_param_diag #(.NUM_CH(4)) analog_out_param_diag_inst (.clk(clk), .rst_n(rst_n), .rec_req(rec_req),
    .rec_rsp(rec_rsp), .out_value(out_value), .short_sense(short_sense), .aux_supply_missing(aux_supply_missing),
    .module_fault(module_fault), .diag_buffer_overflow(diag_buffer_overflow),
    .internal_comm_error(internal_comm_error), .dac_code(dac_code), .channel_active(channel_active),
    .channel_error_led(channel_error_led), .group_error_led(group_error_led));
  coupler_model coupler_model_inst (.clk(clk), .rec_req(rec_req), .rec_rsp(rec_rsp));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction : rnd
  // reset image of diagnostic bytes 0..15
  function automatic logic [7:0] cexp(int i);
    case (i)
      1: return 8'h15;
      4: return 8'h73;
      5: return 8'h08;
      6: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction : cexp
  // negative clamps to zero, large clamps to the overrange limit
  function automatic logic [11:0] dac_exp(logic [7:0] c, logic [15:0] v);
    logic [31:0] d;
    logic        w;
    w = (c == aout_diag_pkg::RANGE_WIDE);
    if (!w && c != aout_diag_pkg::RANGE_NARROW) return 12'h000;
    d = v[15] ? 32'h0 : 32'(v);
    if (d > 32'(w ? aout_diag_pkg::WIDE_OVER : aout_diag_pkg::NARROW_OVER))
      d = 32'(w ? aout_diag_pkg::WIDE_OVER : aout_diag_pkg::NARROW_OVER);
    return 12'((d * 32'(w ? aout_diag_pkg::WIDE_GAIN : aout_diag_pkg::NARROW_GAIN)) >> 16);
  endfunction : dac_exp
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(logic wr, logic [7:0] rec, logic [4:0] idx, logic [7:0] wd);
    coupler_model_inst.access(wr, rec, idx, wd, rd, er);
  endtask : acc
  task automatic rdchk(string n, logic [7:0] rec, logic [4:0] idx, logic [7:0] e);
    acc(1'b0, rec, idx, 8'h00);
    chk(n, {er, e}, {1'b0, rd});
  endtask : rdchk
  task automatic stamp(output logic [31:0] s);
    for (int i = 16; i < 20; i++) begin
      acc(1'b0, 8'h01, 5'(i), 8'h00);
      s = {s[23:0], rd};
    end
  endtask : stamp
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    seed = 32'h00011480;
    {rst_n, aux_supply_missing, module_fault, diag_buffer_overflow, internal_comm_error} = '0;
    out_value = '0;
    short_sense = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 16; i++) rdchk("full record", 8'h01, 5'(i), cexp(i));
    for (int i = 0; i < 4; i++) rdchk("short record", 8'h00, 5'(i), cexp(i));
    acc(1'b0, 8'h00, 5'h04, 8'h00); chk("short overrun err", 1, er);
    acc(1'b0, 8'h01, 5'h14, 8'h00); chk("full overrun err", 1, er);
    acc(1'b0, 8'h05, 5'h00, 8'h00); chk("unknown record err", 1, er);
    acc(1'b1, 8'h01, 5'h00, 8'h5a); chk("diag write err", 1, er);
    $display("test record map done");
    for (int k = 0; k < 8; k++) begin
      code = (k < 6) ? ((k[0]) ? 8'h20 : 8'h10) : ((k[0]) ? 8'hff : 8'h33);
      out_value = {rnd() & 16'h7fff, 16'h7fff, 16'h8000 | rnd(), rnd()};
      for (int c = 0; c < 4; c++) acc(1'b1, 8'h80 + 8'(c), 5'h00, code);
      repeat (6) @(negedge clk);
      for (int c = 0; c < 4; c++) begin
        chk("dac code", dac_exp(code, out_value[c]), dac_code[c]);
        chk("active", (code == 8'h10 || code == 8'h20), channel_active[c]);
        rdchk("range readback", 8'h80 + 8'(c), 5'h00, code);
        rdchk("chan detail", 8'h01, 5'h08 + 5'(c), (code == 8'h33) ? 8'h01 : 8'h00);
      end
      rdchk("flags", 8'h01, 5'h00, (code == 8'h33) ? 8'h88 : 8'h00);
      rdchk("summary", 8'h01, 5'h07, (code == 8'h33) ? 8'h0f : 8'h00);
      chk("chan leds", (code == 8'h33) ? 4'hf : 4'h0, channel_error_led);
    end
    for (int c = 0; c < 4; c++) acc(1'b1, 8'h80 + 8'(c), 5'h00, 8'h10);
    $display("test ranges done");
    acc(1'b1, 8'h00, 5'h01, 8'hf2);
    short_sense = 4'b0110;
    repeat (8) @(negedge clk);
    rdchk("enabled short", 8'h01, 5'h09, 8'h08);
    rdchk("disabled short", 8'h01, 5'h0a, 8'h00);
    rdchk("short flags", 8'h01, 5'h00, 8'h0c);
    rdchk("short summary", 8'h01, 5'h07, 8'h02);
    chk("short leds", 4'h2, channel_error_led);
    stamp(t1);
    chk("stamp range", 1, t1 != 0 && t1 <= 32'(cyc / 20));
    short_sense = 4'b0000;
    repeat (8) @(negedge clk);
    rdchk("short cleared", 8'h01, 5'h09, 8'h00);
    stamp(t2);
    chk("stamp moves", 1, t2 > t1);
    $display("test short done");
    {module_fault, diag_buffer_overflow, aux_supply_missing} = 3'b111;
    repeat (6) @(negedge clk);
    rdchk("internal flags", 8'h01, 5'h00, 8'h13);
    rdchk("overflow byte", 8'h00, 5'h03, 8'h08);
    chk("group led", 1, group_error_led);
    {diag_buffer_overflow, internal_comm_error} = 2'b01;
    repeat (6) @(negedge clk);
    rdchk("comm byte", 8'h01, 5'h03, 8'h10);
    {module_fault, internal_comm_error, aux_supply_missing} = 3'b000;
    repeat (6) @(negedge clk);
    rdchk("flags cleared", 8'h01, 5'h00, 8'h00);
    $display("test internal done");
    final_report();
  end
endmodule : tb
